// *** verilog/ssf_cfg.svh ***
// constants for the scan, flush and pause control block
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH
// register indices; byte address is four times the index
`define SSF_IDX_POLL 8'h86
`define SSF_IDX_FCTRL 8'h88
`define SSF_IDX_FPORT 8'h89
`define SSF_IDX_FVLAN 8'h8A
`define SSF_IDX_PAUSE 8'h90
`define SSF_IDX_IST 8'hA0
`define SSF_IDX_IMASK 8'hA1
`define SSF_IDX_OVR 8'hA2
// field positions
`define SSF_B_POLL_EN 7
`define SSF_B_POLL_INC 5
`define SSF_B_GO 7
`define SSF_B_STATIC 0
`define SSF_B_ALLPORT 7
`define SSF_B_ALLVID 15
`define SSF_B_SKIP_TYPE 1
`define SSF_B_SKIP_DEST 0
`define SSF_B_OVR_EN 7
`define SSF_B_OVR_LINK 0
`define SSF_EV_FLUSH 0
`define SSF_EV_LINK 1
// reset values
`define SSF_RST_POLL_INC 1'b1
`define SSF_RST_BASE 5'h00
`define SSF_RST_OVR_LINK 1'b1
// management frame
`define SSF_CLK_NS 40
`define SSF_MDC_HALF_NS 200
`define SSF_PREAMBLE 32'hFFFFFFFF
`define SSF_MDIO_HEAD 4'h6
`define SSF_STAT_REG 5'h01
`define SSF_LINK_BIT 2
`define SSF_DRIVE_BITS 6'd46
`define SSF_DATA_FIRST 6'd48
`define SSF_FRAME_LAST 6'd63
`endif

// *** verilog/ssf_pkg.sv ***
// types for the scan, flush and pause control block
`default_nettype none
package ssf_pkg;
	typedef struct packed {
		logic valid;
		logic is_static;
		logic [3:0] port;
		logic [11:0] vid;
	} table_entry_t;
	typedef enum logic [1:0] {
		F_IDLE = 2'b00,
		F_READ = 2'b01,
		F_CHECK = 2'b10,
		F_CLEAR = 2'b11
	} flush_state_t;
	typedef enum logic [0:0] {
		P_IDLE = 1'b0,
		P_FRAME = 1'b1
	} poll_state_t;
endpackage : ssf_pkg
`default_nettype wire

// *** verilog/switch_scan_flush_pause_ctrl.sv ***
// register bank with transceiver poller, table flush and pause checks
//
// Notes on behaviour
// - poll enable runs the status poller
// - poll enable resets to inverted strap
// - port address is base plus/minus port
// - base field is port 0 address
// - writing go starts a table flush
// - go bit self-clears when flush ends
// - flush needs port, vlan, type match
// - static entries flushed only if included
// - every-port bit matches all ports
// - port field selects flushed port
// - every-vlan bit matches all vlans
// - vlan field selects flushed vlan
// - skip-type bit drops ethertype check
// - skip-dest bit drops address check
// - override replaces polled link state
`timescale 1ns/1ps
`default_nettype none
`include "ssf_cfg.svh"
module switch_scan_flush_pause_ctrl
	import ssf_pkg::*;
#(
	parameter int NUM_PORTS = 16,
	parameter int TABLE_DEPTH = 4096
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [9:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic IRQ,
	input wire logic AUTO_POLL_DIS,
	output logic MDC,
	output logic MDIO_O,
	output logic MDIO_OE,
	input wire logic MDIO_I,
	output logic [NUM_PORTS-1:0] LINK_STATE,
	output logic [$clog2(TABLE_DEPTH)-1:0] TBL_ADDR,
	input wire table_entry_t TBL_ENTRY,
	output logic TBL_CLR,
	output logic PAUSE_SKIP_TYPE,
	output logic PAUSE_SKIP_DEST
);
	localparam int AW = $clog2(TABLE_DEPTH);
	localparam int PW = $clog2(NUM_PORTS);
	localparam int HALF = (`SSF_MDC_HALF_NS + `SSF_CLK_NS - 1) / `SSF_CLK_NS;
	localparam logic [3:0] HALF_M1 = 4'(HALF - 1);
	localparam logic [AW-1:0] LAST = AW'(TABLE_DEPTH - 1);
	localparam logic [PW-1:0] PLAST = PW'(NUM_PORTS - 1);

	// refuse sizes the port field, counters or divider cannot hold
	if (NUM_PORTS < 2 || NUM_PORTS > 16 || TABLE_DEPTH < 2
		|| HALF > 16) begin : g_bad_params
		$error("unsupported parameter values");
	end

	// ****************************************
	// synchronisers and registers
	// ****************************************
	logic [1:0] strap_sync, mdio_sync;
	logic strap_s, mdio_s;
	logic strap_done, next_strap_done;
	logic poll_en, next_poll_en;
	logic poll_inc, next_poll_inc;
	logic [4:0] poll_base, next_poll_base;
	logic go, next_go;
	logic incl_static, next_incl_static;
	logic every_port, next_every_port;
	logic [3:0] port_sel, next_port_sel;
	logic every_vlan, next_every_vlan;
	logic [11:0] vid_sel, next_vid_sel;
	logic [1:0] pause, next_pause;
	logic ovr_en, next_ovr_en;
	logic ovr_link, next_ovr_link;
	logic [1:0] ist, next_ist, imask, next_imask, events;
	logic [31:0] next_dat, rd_val;
	logic next_ack, wr, rd;
	logic [7:0] idx;

	assign strap_s = strap_sync[1];
	assign mdio_s = mdio_sync[1];
	assign idx = WB_ADR_I[9:2];
	assign wr = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I;
	assign rd = WB_CYC_I && WB_STB_I && WB_ACK_O && !WB_WE_I;

	always_ff @(posedge CLK) begin
		strap_sync <= {strap_sync[0], AUTO_POLL_DIS};
		mdio_sync <= {mdio_sync[0], MDIO_I};
	end

	always_comb begin
		rd_val = 32'h0;
		unique case (idx)
			`SSF_IDX_POLL: begin
				rd_val[`SSF_B_POLL_EN] = poll_en;
				rd_val[`SSF_B_POLL_INC] = poll_inc;
				rd_val[4:0] = poll_base;
			end
			`SSF_IDX_FCTRL: begin
				rd_val[`SSF_B_GO] = go;
				rd_val[`SSF_B_STATIC] = incl_static;
			end
			`SSF_IDX_FPORT: begin
				rd_val[`SSF_B_ALLPORT] = every_port;
				rd_val[3:0] = port_sel;
			end
			`SSF_IDX_FVLAN: begin
				rd_val[`SSF_B_ALLVID] = every_vlan;
				rd_val[11:0] = vid_sel;
			end
			`SSF_IDX_PAUSE: rd_val[1:0] = pause;
			`SSF_IDX_IST: rd_val[1:0] = ist;
			`SSF_IDX_IMASK: rd_val[1:0] = imask;
			`SSF_IDX_OVR: begin
				rd_val[`SSF_B_OVR_EN] = ovr_en;
				rd_val[`SSF_B_OVR_LINK] = ovr_link;
			end
			default: rd_val = 32'h0;
		endcase
	end

	logic flush_done;
	always_comb begin
		next_ack = WB_CYC_I && WB_STB_I && !WB_ACK_O;
		next_dat = next_ack ? rd_val : 32'h0;
		next_strap_done = 1'b1;
		next_poll_en = poll_en;
		if (!strap_done)
			next_poll_en = !strap_s;
		next_poll_inc = poll_inc;
		next_poll_base = poll_base;
		next_go = flush_done ? 1'b0 : go;
		next_incl_static = incl_static;
		next_every_port = every_port;
		next_port_sel = port_sel;
		next_every_vlan = every_vlan;
		next_vid_sel = vid_sel;
		next_pause = pause;
		next_ovr_en = ovr_en;
		next_ovr_link = ovr_link;
		next_imask = imask;
		next_ist = ist;
		if (rd && idx == `SSF_IDX_IST)
			next_ist = 2'h0;
		next_ist = next_ist | events;
		if (wr && WB_SEL_I[0]) begin
			unique case (idx)
				`SSF_IDX_POLL: begin
					next_poll_en = WB_DAT_I[`SSF_B_POLL_EN];
					next_poll_inc = WB_DAT_I[`SSF_B_POLL_INC];
					next_poll_base = WB_DAT_I[4:0];
				end
				`SSF_IDX_FCTRL: begin
					if (WB_DAT_I[`SSF_B_GO])
						next_go = 1'b1;
					next_incl_static = WB_DAT_I[`SSF_B_STATIC];
				end
				`SSF_IDX_FPORT: begin
					next_every_port = WB_DAT_I[`SSF_B_ALLPORT];
					next_port_sel = WB_DAT_I[3:0];
				end
				`SSF_IDX_FVLAN: next_vid_sel[7:0] = WB_DAT_I[7:0];
				`SSF_IDX_PAUSE: next_pause = WB_DAT_I[1:0];
				`SSF_IDX_IMASK: next_imask = WB_DAT_I[1:0];
				`SSF_IDX_OVR: begin
					next_ovr_en = WB_DAT_I[`SSF_B_OVR_EN];
					next_ovr_link = WB_DAT_I[`SSF_B_OVR_LINK];
				end
				default: ;
			endcase
		end
		if (wr && WB_SEL_I[1] && idx == `SSF_IDX_FVLAN) begin
			next_every_vlan = WB_DAT_I[`SSF_B_ALLVID];
			next_vid_sel[11:8] = WB_DAT_I[11:8];
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0;
			strap_done <= 1'b0;
			poll_en <= 1'b0;
			poll_inc <= `SSF_RST_POLL_INC;
			poll_base <= `SSF_RST_BASE;
			go <= 1'b0;
			incl_static <= 1'b0;
			every_port <= 1'b0;
			port_sel <= 4'h0;
			every_vlan <= 1'b0;
			vid_sel <= 12'h000;
			pause <= 2'h0;
			ovr_en <= 1'b0;
			ovr_link <= `SSF_RST_OVR_LINK;
			ist <= 2'h0;
			imask <= 2'h0;
			IRQ <= 1'b0;
			PAUSE_SKIP_TYPE <= 1'b0;
			PAUSE_SKIP_DEST <= 1'b0;
		end else begin
			WB_ACK_O <= next_ack;
			WB_DAT_O <= next_dat;
			strap_done <= next_strap_done;
			poll_en <= next_poll_en;
			poll_inc <= next_poll_inc;
			poll_base <= next_poll_base;
			go <= next_go;
			incl_static <= next_incl_static;
			every_port <= next_every_port;
			port_sel <= next_port_sel;
			every_vlan <= next_every_vlan;
			vid_sel <= next_vid_sel;
			pause <= next_pause;
			ovr_en <= next_ovr_en;
			ovr_link <= next_ovr_link;
			ist <= next_ist;
			imask <= next_imask;
			IRQ <= |(next_ist & next_imask);
			PAUSE_SKIP_TYPE <= next_pause[`SSF_B_SKIP_TYPE];
			PAUSE_SKIP_DEST <= next_pause[`SSF_B_SKIP_DEST];
		end
	end

	// ****************************************
	// table flush engine
	// ****************************************
	flush_state_t fst, next_fst;
	logic [AW-1:0] next_addr;
	logic next_clr, hit_port, hit_vlan, hit_type, hit;

	always_comb begin
		hit_port = every_port || TBL_ENTRY.port == port_sel;
		hit_vlan = every_vlan || TBL_ENTRY.vid == vid_sel;
		hit_type = incl_static || !TBL_ENTRY.is_static;
		hit = TBL_ENTRY.valid && hit_port && hit_vlan && hit_type;
		next_fst = fst;
		next_addr = TBL_ADDR;
		next_clr = 1'b0;
		flush_done = 1'b0;
		unique case (fst)
			F_IDLE: begin
				if (go) begin
					next_addr = '0;
					next_fst = F_READ;
				end
			end
			F_READ: next_fst = F_CHECK;
			F_CHECK, F_CLEAR: begin
				if (fst == F_CHECK && hit) begin
					next_clr = 1'b1;
					next_fst = F_CLEAR;
				end else if (TBL_ADDR == LAST) begin
					flush_done = 1'b1;
					next_fst = F_IDLE;
				end else begin
					next_addr = TBL_ADDR + 1'b1;
					next_fst = F_READ;
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			fst <= F_IDLE;
			TBL_ADDR <= '0;
			TBL_CLR <= 1'b0;
		end else begin
			fst <= next_fst;
			TBL_ADDR <= next_addr;
			TBL_CLR <= next_clr;
		end
	end

	// ****************************************
	// transceiver poller
	// ****************************************
	poll_state_t pst, next_pst;
	logic [PW-1:0] pport, next_pport;
	logic [5:0] bitn, next_bitn;
	logic [3:0] div, next_div;
	logic [45:0] hdr, next_hdr;
	logic [15:0] shin, next_shin;
	logic [NUM_PORTS-1:0] lpoll, next_lpoll;
	logic [4:0] taddr;
	logic next_mdc, next_mo, next_oe, link_ev;

	assign taddr = poll_inc ? 5'(poll_base + 5'(pport))
		: 5'(poll_base - 5'(pport));
	assign events = {link_ev, flush_done};

	always_comb begin
		next_pst = pst;
		next_pport = pport;
		next_bitn = bitn;
		next_div = div;
		next_hdr = hdr;
		next_shin = shin;
		next_lpoll = lpoll;
		next_mdc = MDC;
		next_mo = MDIO_O;
		next_oe = MDIO_OE;
		link_ev = 1'b0;
		unique case (pst)
			P_IDLE: begin
				next_mdc = 1'b0;
				next_oe = 1'b0;
				next_mo = 1'b0;
				if (poll_en) begin
					next_hdr = {`SSF_PREAMBLE, `SSF_MDIO_HEAD, taddr,
						`SSF_STAT_REG};
					next_bitn = 6'd0;
					next_div = 4'h0;
					next_mo = next_hdr[45];
					next_oe = 1'b1;
					next_pst = P_FRAME;
				end
			end
			P_FRAME: begin
				next_div = div + 4'h1;
				if (div == HALF_M1) begin
					next_div = 4'h0;
					next_mdc = !MDC;
					if (!MDC && bitn >= `SSF_DATA_FIRST)
						next_shin = {shin[14:0], mdio_s};
					if (MDC) begin
						next_bitn = bitn + 6'd1;
						next_hdr = {hdr[44:0], 1'b0};
						next_mo = next_hdr[45];
						next_oe = next_bitn < `SSF_DRIVE_BITS;
						if (bitn == `SSF_FRAME_LAST) begin
							next_lpoll[pport] = shin[`SSF_LINK_BIT];
							link_ev = lpoll[pport] != shin[`SSF_LINK_BIT];
							next_pport = pport == PLAST ? '0
								: pport + 1'b1;
							next_oe = 1'b0;
							next_pst = P_IDLE;
						end
					end
				end
				if (!poll_en) begin
					next_mdc = 1'b0;
					next_oe = 1'b0;
					next_mo = 1'b0;
					next_pst = P_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			pst <= P_IDLE;
			pport <= '0;
			bitn <= 6'd0;
			div <= 4'h0;
			hdr <= '0;
			shin <= 16'h0000;
			lpoll <= '0;
			MDC <= 1'b0;
			MDIO_O <= 1'b0;
			MDIO_OE <= 1'b0;
			LINK_STATE <= '0;
		end else begin
			pst <= next_pst;
			pport <= next_pport;
			bitn <= next_bitn;
			div <= next_div;
			hdr <= next_hdr;
			shin <= next_shin;
			lpoll <= next_lpoll;
			MDC <= next_mdc;
			MDIO_O <= next_mo;
			MDIO_OE <= next_oe;
			LINK_STATE <= ovr_en ? {NUM_PORTS{ovr_link}} : next_lpoll;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence s_check;
		fst == F_CHECK;
	endsequence
	sequence s_last_step;
		s_check ##0 (!hit && TBL_ADDR == LAST);
	endsequence

	AST_GO_CLEARS: assert property (@(posedge CLK) disable iff (SRST)
		s_last_step |=> !go || $past(wr))
		else $error("go bit not cleared at flush end");
	AST_STATIC_KEPT: assert property (@(posedge CLK) disable iff (SRST)
		s_check ##0 (TBL_ENTRY.is_static && !incl_static) |=> !TBL_CLR)
		else $error("static entry flushed");
	AST_PORT_KEPT: assert property (@(posedge CLK) disable iff (SRST)
		s_check ##0 (!every_port && TBL_ENTRY.port != port_sel) |=> !TBL_CLR)
		else $error("wrong port flushed");
	AST_VLAN_KEPT: assert property (@(posedge CLK) disable iff (SRST)
		s_check ##0 (!every_vlan && TBL_ENTRY.vid != vid_sel) |=> !TBL_CLR)
		else $error("wrong vlan flushed");
	AST_ALL_MATCH: assert property (@(posedge CLK) disable iff (SRST)
		s_check ##0 (TBL_ENTRY.valid && every_port && every_vlan
		&& incl_static) |=> TBL_CLR ##1 !TBL_CLR)
		else $error("matching entry not flushed");
	AST_CLR_BUSY: assert property (@(posedge CLK) disable iff (SRST)
		TBL_CLR |-> go && $stable(TBL_ADDR))
		else $error("clear outside a flush");
	AST_POLL_STOP: assert property (@(posedge CLK) disable iff (SRST)
		!poll_en ##1 !poll_en |=> !MDIO_OE && !MDC)
		else $error("poller runs while disabled");
	AST_ADDR_SEQ: assert property (@(posedge CLK) disable iff (SRST)
		(pst == P_IDLE && poll_en) |=> hdr[9:5] == ($past(poll_inc)
		? 5'($past(poll_base) + 5'($past(pport)))
		: 5'($past(poll_base) - 5'($past(pport)))))
		else $error("wrong transceiver address");
	AST_OVERRIDE: assert property (@(posedge CLK) disable iff (SRST)
		ovr_en |=> LINK_STATE == {NUM_PORTS{$past(ovr_link)}})
		else $error("override not applied");
	AST_PAUSE_MAP: assert property (@(posedge CLK) disable iff (SRST)
		$past(pause) == pause |-> PAUSE_SKIP_TYPE == pause[1]
		&& PAUSE_SKIP_DEST == pause[0])
		else $error("pause check bits wrong");
	AST_ACK_PULSE: assert property (@(posedge CLK) disable iff (SRST)
		WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
endmodule : switch_scan_flush_pause_ctrl
`default_nettype wire

// *** dv/xcvr_model.sv ***
// behavioural model of the polled transceivers on the management bus
`timescale 1ns/1ps
`default_nettype none
module xcvr_model (
	input wire logic MDC,
	input wire logic MDIO_O,
	input wire logic MDIO_OE,
	input wire logic [31:0] LINK_MAP,
	output logic MDIO_I
);
	int cnt = 0;
	logic [4:0] sh = 5'h00;
	logic [15:0] stat = 16'h0000;
	logic drv = 1'b1;
	logic [4:0] addrs [$];
	always @(posedge MDIO_OE) cnt = 0;
	always @(posedge MDC) begin
		if (MDIO_OE)
			sh = {sh[3:0], MDIO_O};
		if (cnt == 40) begin
			stat = 16'h0000;
			stat[2] = LINK_MAP[sh];
			addrs.push_back(sh);
		end
		cnt++;
	end
	// turnaround low, then status msb first, else pull-up
	always @(negedge MDC) begin
		if (cnt == 47)
			drv = 1'b0;
		else if (cnt >= 48 && cnt <= 63)
			drv = stat[63-cnt];
		else
			drv = 1'b1;
	end
	assign MDIO_I = MDIO_OE ? MDIO_O : drv;
endmodule : xcvr_model
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the scan, flush and pause control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ssf_pkg::*;
	logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] dat = 32'h0, dout, q;
	logic ack, irq, strap = 1'b1, mdc, mdo, mdoe, mdi, tclr, skt, skd;
	logic [15:0] link;
	logic [2:0] taddr;
	table_entry_t tent = '0;
	table_entry_t tbl [8];
	int errors = 0, tests_run = 0;
	localparam table_entry_t INIT [8] = '{{1'b1, 1'b0, 4'h3, 12'h010},
		{1'b1, 1'b1, 4'h3, 12'h010}, {1'b1, 1'b0, 4'h3, 12'h020},
		{1'b1, 1'b0, 4'h5, 12'h010}, {1'b1, 1'b1, 4'h5, 12'h020},
		{1'b0, 1'b0, 4'h3, 12'h010}, {1'b1, 1'b0, 4'h5, 12'hFFF},
		{1'b1, 1'b1, 4'h3, 12'hFFF}};
	always #20 clk = ~clk;
	switch_scan_flush_pause_ctrl #(.NUM_PORTS(16), .TABLE_DEPTH(8)) i_dut (
		.CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(dat),
		.WB_DAT_O(dout), .WB_ACK_O(ack), .IRQ(irq), .AUTO_POLL_DIS(strap),
		.MDC(mdc), .MDIO_O(mdo), .MDIO_OE(mdoe), .MDIO_I(mdi),
		.LINK_STATE(link), .TBL_ADDR(taddr), .TBL_ENTRY(tent),
		.TBL_CLR(tclr), .PAUSE_SKIP_TYPE(skt), .PAUSE_SKIP_DEST(skd));
	xcvr_model i_phy (.MDC(mdc), .MDIO_O(mdo), .MDIO_OE(mdoe),
		.LINK_MAP(32'h02000020), .MDIO_I(mdi));
	// synchronous-read table
	always @(posedge clk) begin
		tent <= tbl[taddr];
		if (tclr === 1'b1)
			tbl[taddr].valid <= 1'b0;
	end
	task results;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, s);
			errors++;
		end
	endtask : chk
	task fail(input string nm);
		$display("mismatch %s expected done seen timeout", nm);
		errors++;
		results();
	endtask : fail
	task wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1)
			fail("bus ack");
		q = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	function automatic logic hit(table_entry_t e, logic [31:0] c);
		return (c[0] | ~e.is_static) & (c[31] | (e.port == c[27:24]))
			& (c[23] | (e.vid == c[19:8]));
	endfunction : hit
	// ****
	// scenarios
	// ****
	task t_reset;
		wb(0, 8'h86, 0);
		chk("poll ctrl", 32'h20, q);
		wb(0, 8'h88, 0);
		chk("flush ctrl", 0, q);
		wb(0, 8'h90, 0);
		chk("pause ctrl", 0, q);
		wb(0, 8'h55, 0);
		chk("unmapped", 0, q);
		$display("test reset done");
	endtask : t_reset
	task t_regs;
		wb(1, 8'h90, 32'hFF);
		wb(0, 8'h90, 0);
		chk("pause rd", 32'h3, q);
		chk("skip outs", 2'b11, {skt, skd});
		wb(1, 8'h90, 32'h1);
		repeat (2) @(posedge clk);
		chk("skip outs", 2'b01, {skt, skd});
		wb(1, 8'h89, 32'hFF);
		wb(0, 8'h89, 0);
		chk("port rd", 32'h8F, q);
		wb(1, 8'h8A, 32'hFFFF);
		wb(0, 8'h8A, 0);
		chk("vlan rd", 32'h8FFF, q);
		wb(1, 8'h88, 32'h7F);
		wb(0, 8'h88, 0);
		chk("flush ctrl rd", 32'h1, q);
		wb(1, 8'h86, 32'h5F);
		wb(0, 8'h86, 0);
		chk("poll ctrl rd", 32'h1F, q);
		$display("test registers done");
	endtask : t_regs
	task t_flush;
		logic [31:0] cs [4];
		logic [7:0] want, got;
		int n;
		cs = '{32'h03001080, 32'h80001081, 32'h05800080, 32'h80800081};
		wb(1, 8'hA1, 32'h1);
		for (int c = 0; c < 4; c++) begin
			for (int i = 0; i < 8; i++)
				tbl[i] = INIT[i];
			wb(1, 8'h89, {24'h0, cs[c][31:24]});
			wb(1, 8'h8A, {16'h0, cs[c][23:8]});
			wb(1, 8'h88, {24'h0, cs[c][7:0]});
			n = 0;
			q = 32'h80;
			while (q[7] !== 1'b0 && n < 100) begin
				wb(0, 8'h88, 0);
				n++;
			end
			if (n >= 100)
				fail("flush done");
			chk("go bit", {31'h0, cs[c][0]}, q);
			for (int i = 0; i < 8; i++) begin
				want[i] = INIT[i].valid & ~hit(INIT[i], cs[c]);
				got[i] = tbl[i].valid;
			end
			chk("table", want, got);
			repeat (2) @(posedge clk);
			chk("irq set", 1, irq);
			wb(0, 8'hA0, 0);
			chk("done status", 1, q[0]);
			repeat (2) @(posedge clk);
			chk("irq clear", 0, irq);
		end
		$display("test flush done");
	endtask : t_flush
	task t_poll;
		int n, p;
		logic act;
		i_phy.addrs.delete();
		// consecutive addresses downward from 5
		wb(1, 8'h86, 32'h85);
		n = 0;
		while (i_phy.addrs.size() < 14 && n < 12000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 12000)
			fail("poll frames");
		for (int k = 0; k < 13; k++)
			chk("dec addr", (5 - k) & 31, {27'h0, i_phy.addrs[k]});
		chk("link", 3'b101, {link[12], link[1], link[0]});
		wb(0, 8'hA0, 0);
		chk("link change", 32'h2, q);
		wb(1, 8'h86, 32'h25);
		repeat (3) @(posedge clk);
		act = 1'b0;
		repeat (200) begin
			@(posedge clk);
			act |= mdc | mdoe;
		end
		chk("idle mgmt bus", 0, act);
		i_phy.addrs.delete();
		wb(1, 8'hA5, 0);
		wb(1, 8'h86, 32'hA5);
		n = 0;
		while (i_phy.addrs.size() < 3 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000)
			fail("inc frames");
		for (int k = 0; k < 2; k++) begin
			p = i_phy.addrs[k];
			chk("inc addr", ((p - 4) & 15) + 5, i_phy.addrs[k+1]);
		end
		wb(1, 8'hA2, 32'h80);
		repeat (2) @(posedge clk);
		chk("override down", 0, link);
		wb(1, 8'hA2, 32'h81);
		repeat (2) @(posedge clk);
		chk("override up", 32'hFFFF, link);
		$display("test poll done");
	endtask : t_poll
	// mid-run reset with the strap low: polling must come up enabled
	task t_strap;
		strap <= 1'b0;
		srst <= 1'b1;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		wb(0, 8'h86, 0);
		chk("strap low", 32'hA0, q);
		chk("skip outs", 0, {skt, skd});
		chk("link reset", 0, link);
		$display("test strap done");
	endtask : t_strap
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_regs();
		t_flush();
		t_poll();
		t_strap();
		results();
	end
	initial begin
		repeat (40000) @(posedge clk);
		fail("run time");
	end
endmodule : testbench
`default_nettype wire
